// ==== src/lfwdt_host.sv ====
`timescale 1ns/10ps
module lfwdt_host (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// link to the watchdog end
	lfwdt_if.host bus,
	// user commands
	input wire logic start,
	input wire logic [15:0] interval,
	input wire logic [3:0] ignore,
	input wire logic service,
	input wire logic key_write,
	input wire logic [31:0] key_value,
	input wire logic cause_clear,
	input wire lfwdt_pkg::lfwdt_mode_e mode,
	// user status
	output logic busy,
	output logic cpu_irq_enable_set,
	output logic [15:0] count_seen,
	output logic reset_cause_seen
);
	typedef enum logic [2:0] {
		LFWDT_IDLE = 3'b000,
		LFWDT_CFG = 3'b001,
		LFWDT_CLR = 3'b010,
		LFWDT_MASK = 3'b011,
		LFWDT_CPU = 3'b100,
		LFWDT_RUN = 3'b101,
		LFWDT_ISR = 3'b110
	} lfwdt_hst_e;

	typedef struct packed {
		lfwdt_hst_e fsm;
		logic [15:0] step;
		logic [3:0] ign;
		logic cpu_en;
		logic key_wr;
		logic [31:0] key_data;
		logic match_wr;
		logic [15:0] match_data;
		logic clr;
		logic mask_wr;
		logic cause_clr;
		logic [15:0] count;
		logic cause;
	} lfwdt_hst_s;

	lfwdt_hst_s st;
	lfwdt_hst_s next_st;

	// configuration sequence and periodic service
	always_comb begin
		next_st = st;
		next_st.key_wr = 1'b0;
		next_st.match_wr = 1'b0;
		next_st.clr = 1'b0;
		next_st.mask_wr = 1'b0;
		next_st.cause_clr = cause_clear;
		next_st.count = bus.count_value_reg;
		next_st.cause = bus.watchdog_reset_cause_bit;
		if (key_write) begin
			next_st.key_wr = 1'b1;
			next_st.key_data = key_value;
		end
		unique case (st.fsm)
			LFWDT_IDLE: begin
				if (start) begin
					next_st.step = interval;
					next_st.ign = ignore;
					next_st.cpu_en = 1'b0;
					next_st.fsm = LFWDT_CFG;
				end
			end
			LFWDT_CFG: begin
				// ignore bits and match value in one write, counter keeps running
				next_st.match_wr = 1'b1;
				next_st.match_data = bus.count_value_reg + st.step;
				next_st.fsm = LFWDT_CLR;
			end
			LFWDT_CLR: begin
				next_st.clr = 1'b1;
				next_st.fsm = LFWDT_MASK;
			end
			LFWDT_MASK: begin
				next_st.mask_wr = 1'b1;
				next_st.fsm = LFWDT_CPU;
			end
			LFWDT_CPU: begin
				next_st.cpu_en = 1'b1;
				next_st.fsm = LFWDT_RUN;
			end
			LFWDT_RUN: begin
				// main-code service clears the flag
				if (service) begin
					next_st.clr = 1'b1;
				end
				// routine service only while the reset is suppressed, main code owns it otherwise
				if ((bus.irq || bus.wakeup) && bus.reset_disabled) begin
					next_st.clr = 1'b1;
					next_st.match_wr = 1'b1;
					next_st.match_data = bus.match_value_reg + st.step;
					next_st.fsm = LFWDT_ISR;
				end
			end
			LFWDT_ISR: begin
				// one cycle for the cleared flag to reach the irq line
				next_st.fsm = LFWDT_RUN;
			end
			default: begin
				next_st.fsm = LFWDT_IDLE;
			end
		endcase
	end

	// registered state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '{fsm: LFWDT_IDLE, step: 16'h0000, ign: 4'h0, cpu_en: 1'b0, key_wr: 1'b0,
				key_data: 32'h0000_0000, match_wr: 1'b0, match_data: 16'h0000, clr: 1'b0,
				mask_wr: 1'b0, cause_clr: 1'b0, count: 16'h0000, cause: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// drive the link from flops, mask data tied high and power mode taken straight from the mode input
	assign bus.key_wr = st.key_wr;
	assign bus.key_data = st.key_data;
	assign bus.match_wr = st.match_wr;
	assign bus.match_data = st.match_data;
	assign bus.ignore_data = st.ign;
	assign bus.intr_clear_wr = st.clr;
	assign bus.mask_wr = st.mask_wr;
	assign bus.mask_data = 1'b1;
	assign bus.cause_clear_wr = st.cause_clr;
	assign bus.power_mode = mode;
	// user status
	assign busy = (st.fsm != LFWDT_IDLE) && (st.fsm != LFWDT_RUN) && (st.fsm != LFWDT_ISR);
	assign cpu_irq_enable_set = st.cpu_en;
	assign count_seen = st.count;
	assign reset_cause_seen = st.cause;
endmodule // lfwdt_host

// ==== src/lfwdt_pkg.sv ====
package lfwdt_pkg;
	// counter geometry
	localparam int COUNT_W = 16;
	localparam int IGN_W = 4;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	localparam logic [3:0] IGNORE_RESET = 4'h0;
	// low-frequency tick derived from the system clock
	localparam int CLK_HZ = 125_000_000;
	localparam int LF_HZ = 40_000;
	localparam int LF_DIV = CLK_HZ / LF_HZ;
	localparam int DIV_W = 12;
	// reset suppression key
	localparam logic [31:0] DISABLE_KEY = 32'hACED_8865;
	// unserviced match events that trigger a device reset
	localparam logic [1:0] MISS_LIMIT = 2'h3;
	// power modes
	typedef enum logic [1:0] {
		LFWDT_ACTIVE = 2'b00,
		LFWDT_SLEEP = 2'b01,
		LFWDT_DEEP = 2'b10
	} lfwdt_mode_e;
endpackage

// ==== src/lfwdt_if.sv ====
`timescale 1ns/10ps
interface lfwdt_if;
	// host writes, each a one-cycle strobe with its data, plus the power mode level
	logic key_wr;
	logic [31:0] key_data;
	logic match_wr;
	logic [15:0] match_data;
	logic [3:0] ignore_data;
	logic intr_clear_wr;
	logic mask_wr;
	logic mask_data;
	logic cause_clear_wr;
	lfwdt_pkg::lfwdt_mode_e power_mode;
	// device state seen by the host
	logic [15:0] count_value_reg;
	logic [15:0] match_value_reg;
	logic [3:0] ignore_bits;
	logic match_flag;
	logic system_interrupt_mask;
	logic irq;
	logic wakeup;
	logic reset_req;
	logic reset_disabled;
	logic watchdog_reset_cause_bit;

	modport dev (
		input key_wr, key_data, match_wr, match_data, ignore_data, intr_clear_wr,
		input mask_wr, mask_data, cause_clear_wr, power_mode,
		output count_value_reg, match_value_reg, ignore_bits, match_flag,
		output system_interrupt_mask, irq, wakeup, reset_req, reset_disabled,
		output watchdog_reset_cause_bit
	);
	modport host (
		output key_wr, key_data, match_wr, match_data, ignore_data, intr_clear_wr,
		output mask_wr, mask_data, cause_clear_wr, power_mode,
		input count_value_reg, match_value_reg, ignore_bits, match_flag,
		input system_interrupt_mask, irq, wakeup, reset_req, reset_disabled,
		input watchdog_reset_cause_bit
	);
endinterface

// ==== src/lfwdt_device.sv ====
// Operation
// - free-running wraparound up-counter, 16-bit at most
// - counter ticks at 40 kHz low-frequency rate
// - match raises interrupt, count keeps going
// - counts to maximum, rolls to zero, rematches
// - match value writable while counter runs
// - flag set per match, write-one clears
// - third unserviced match resets the device
// - discarded top bits shorten the counter
// - interrupts in active mode, wakeups in sleep and deep modes
// - forward only when mask bit set
// - software configures before enabling mask
// - service routine advances match by interval
// - reset period covers longest firmware path
// - service from main code, not routine; the host routine also services while the reset is suppressed
// - key suppresses reset only, counter never stops
// - reset cause bit held until cleared
`timescale 1ns/10ps
module lfwdt_device (
	// clock and power-on, brownout or external reset
	input wire logic clk,
	input wire logic reset_n,
	// link to the host end
	lfwdt_if.dev bus,
	// outputs toward cpu, wakeup controller and reset block
	output logic cpu_irq,
	output logic wakeup_irq_controller,
	output logic device_reset
);
	typedef struct packed {
		logic [lfwdt_pkg::DIV_W-1:0] div;
		logic [15:0] count;
		logic [15:0] match;
		logic [3:0] ignore;
		logic flag;
		logic mask;
		logic [1:0] miss;
		logic disabled;
		logic cause;
		logic rst;
	} lfwdt_dev_s;

	localparam logic [lfwdt_pkg::DIV_W-1:0] DIV_LAST = lfwdt_pkg::DIV_W'(lfwdt_pkg::LF_DIV - 1);

	lfwdt_dev_s st;
	lfwdt_dev_s next_st;
	logic tick;
	logic [15:0] keep_mask;
	logic [15:0] count_inc;
	logic hit;

	// low-frequency enable and the kept-bit mask
	always_comb begin
		tick = (st.div == DIV_LAST);
		keep_mask = lfwdt_pkg::COUNT_MAX >> st.ignore;
		count_inc = (st.count + 16'h0001) & keep_mask;
		hit = tick && ((count_inc & keep_mask) == (st.match & keep_mask));
	end

	// next state
	always_comb begin
		next_st = st;
		next_st.rst = 1'b0;
		next_st.div = tick ? '0 : st.div + 1'b1;
		// counter never stops or clears on match
		if (tick) begin
			next_st.count = count_inc;
		end
		// match and ignore bits take effect without disturbing the count
		if (bus.match_wr) begin
			next_st.match = bus.match_data;
			next_st.ignore = bus.ignore_data;
		end
		if (bus.mask_wr) begin
			next_st.mask = bus.mask_data;
		end
		if (bus.key_wr) begin
			next_st.disabled = (bus.key_data == lfwdt_pkg::DISABLE_KEY);
		end
		// write-one clear, a same-cycle match wins
		if (bus.intr_clear_wr) begin
			next_st.flag = 1'b0;
			next_st.miss = 2'h0;
		end
		if (hit) begin
			next_st.flag = 1'b1;
			if (bus.intr_clear_wr) begin
				next_st.miss = 2'h1;
			end else if (st.miss != lfwdt_pkg::MISS_LIMIT) begin
				next_st.miss = st.miss + 2'h1;
			end
			if (!bus.intr_clear_wr && st.miss == 2'h2 && !st.disabled) begin
				next_st.rst = 1'b1;
				next_st.cause = 1'b1;
			end
		end
		if (bus.cause_clear_wr && !next_st.rst) begin
			next_st.cause = 1'b0;
		end
	end

	// registered state; reset_n stands for power-on, brownout and external reset
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '{div: '0, count: 16'h0000, match: lfwdt_pkg::MATCH_RESET,
				ignore: lfwdt_pkg::IGNORE_RESET, flag: 1'b0, mask: 1'b0, miss: 2'h0,
				disabled: 1'b0, cause: 1'b0, rst: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// routing by power mode, gated by the mask
	always_comb begin
		cpu_irq = st.flag && st.mask && (bus.power_mode == lfwdt_pkg::LFWDT_ACTIVE);
		wakeup_irq_controller = st.flag && st.mask
			&& (bus.power_mode != lfwdt_pkg::LFWDT_ACTIVE);
		device_reset = st.rst;
	end

	// state seen by the host
	assign bus.count_value_reg = st.count;
	assign bus.match_value_reg = st.match;
	assign bus.ignore_bits = st.ignore;
	assign bus.match_flag = st.flag;
	assign bus.system_interrupt_mask = st.mask;
	assign bus.irq = cpu_irq;
	assign bus.wakeup = wakeup_irq_controller;
	assign bus.reset_req = st.rst;
	assign bus.reset_disabled = st.disabled;
	assign bus.watchdog_reset_cause_bit = st.cause;
endmodule // lfwdt_device

// ==== bench/lfwdt_props.sv ====
`timescale 1ns/10ps
module lfwdt_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// host strobes
	input wire logic key_wr,
	input wire logic [31:0] key_data,
	input wire logic match_wr,
	input wire logic [15:0] match_data,
	input wire logic intr_clear_wr,
	input wire lfwdt_pkg::lfwdt_mode_e power_mode,
	// device state
	input wire logic [15:0] count_value_reg,
	input wire logic [15:0] match_value_reg,
	input wire logic [3:0] ignore_bits,
	input wire logic match_flag,
	input wire logic system_interrupt_mask,
	input wire logic irq,
	input wire logic wakeup,
	input wire logic reset_req,
	input wire logic reset_disabled,
	input wire logic watchdog_reset_cause_bit
);
	localparam int GAP = lfwdt_pkg::LF_DIV - 1;
	logic [15:0] msk;
	logic [11:0] gap;
	logic seen;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// kept low-order bits of the count
	assign msk = 16'hFFFF >> ignore_bits;
	// cycles since the count last moved
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			gap <= '0;
			seen <= 1'b0;
		end else if ($changed(count_value_reg)) begin
			gap <= '0;
			seen <= 1'b1;
		end else begin
			gap <= gap + 12'h001;
		end
	end
	a_match_load: assert property (match_wr |=> match_value_reg == $past(match_data))
		else $error("match value not loaded");
	a_key_off: assert property (key_wr && key_data == lfwdt_pkg::DISABLE_KEY |=> reset_disabled)
		else $error("key did not suppress reset");
	a_key_on: assert property (key_wr && key_data != lfwdt_pkg::DISABLE_KEY |=> !reset_disabled)
		else $error("other key did not enable reset");
	a_count_step: assert property ($changed(count_value_reg) && $stable(ignore_bits) |->
		count_value_reg == (($past(count_value_reg) + 16'h0001) & msk))
		else $error("count step wrong");
	a_tick_rate: assert property ($changed(count_value_reg) && seen |-> gap == GAP)
		else $error("count tick spacing wrong");
	a_flag_on_match: assert property ($changed(count_value_reg) && $stable(match_value_reg) &&
		(count_value_reg & msk) == (match_value_reg & msk) |-> match_flag)
		else $error("flag not set on match");
	a_flag_clear: assert property (intr_clear_wr ##1 $stable(count_value_reg) |-> !match_flag)
		else $error("flag not cleared");
	a_irq_route: assert property (irq |-> match_flag && system_interrupt_mask &&
		power_mode == lfwdt_pkg::LFWDT_ACTIVE)
		else $error("cpu request without cause");
	a_wake_route: assert property (wakeup |-> match_flag && system_interrupt_mask &&
		power_mode != lfwdt_pkg::LFWDT_ACTIVE)
		else $error("wakeup without cause");
	a_reset_pulse: assert property (reset_req |=> !reset_req && watchdog_reset_cause_bit)
		else $error("reset pulse or cause wrong");
	// main scenarios
	c_irq: cover property ($rose(irq));
	c_wake: cover property ($rose(wakeup));
	c_key: cover property (key_wr && key_data == lfwdt_pkg::DISABLE_KEY);
	c_reset: cover property (reset_req);
endmodule // lfwdt_props

// ==== bench/lfwdt_tb.sv ====
`timescale 1ns/10ps
module lfwdt_tb;
	logic clk, reset_n, start, service, key_write, cause_clear, busy, cpu_irq_enable_set;
	logic reset_cause_seen, cpu_irq, wakeup_irq_controller, device_reset;
	logic [15:0] interval, count_seen, exp_q[$];
	logic [3:0] ignore;
	logic [31:0] key_value;
	lfwdt_pkg::lfwdt_mode_e mode;
	int miscompares, check_count;
	lfwdt_if bus();
	lfwdt_device i_lfwdt_device(.clk, .reset_n, .bus, .cpu_irq, .wakeup_irq_controller,
		.device_reset);
	lfwdt_host i_lfwdt_host(.clk, .reset_n, .bus, .start, .interval, .ignore, .service,
		.key_write, .key_value, .cause_clear, .mode, .busy, .cpu_irq_enable_set, .count_seen,
		.reset_cause_seen);
	lfwdt_props i_lfwdt_props(.clk, .reset_n, .key_wr(bus.key_wr), .key_data(bus.key_data),
		.match_wr(bus.match_wr), .match_data(bus.match_data), .intr_clear_wr(bus.intr_clear_wr),
		.power_mode(bus.power_mode), .count_value_reg(bus.count_value_reg),
		.match_value_reg(bus.match_value_reg), .ignore_bits(bus.ignore_bits),
		.match_flag(bus.match_flag), .system_interrupt_mask(bus.system_interrupt_mask),
		.irq(bus.irq), .wakeup(bus.wakeup), .reset_req(bus.reset_req),
		.reset_disabled(bus.reset_disabled),
		.watchdog_reset_cause_bit(bus.watchdog_reset_cause_bit));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// one-cycle user pulse, then settle
	task automatic pulse(ref logic sig);
		sig = 1'b1;
		@(negedge clk);
		sig = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic wait_q(input int left);
		int n;
		n = 0;
		while (exp_q.size() > left) begin
			@(negedge clk);
			n++;
			if (n > 40000) begin
				miscompares++;
				stop_test();
			end
		end
	endtask
	// clock source
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// result watcher: each new request pops the oldest noted match
	initial begin : mon
		logic prev;
		prev = 1'b0;
		forever begin
			@(negedge clk);
			if ((cpu_irq | wakeup_irq_controller) && !prev && exp_q.size() > 0) begin
				check(bus.match_value_reg, exp_q[0]);
				check(bus.count_value_reg & (16'hFFFF >> ignore), exp_q.pop_front() & (16'hFFFF >> ignore));
				check({cpu_irq, wakeup_irq_controller}, (mode == lfwdt_pkg::LFWDT_ACTIVE) ? 2'b10 : 2'b01);
			end
			prev = cpu_irq | wakeup_irq_controller;
		end
	end
	// stimulus
	initial begin : main
		logic [15:0] m;
		int n;
		void'($urandom(32'h8197_e5b1));
		{reset_n, start, service, key_write, cause_clear} = 5'h00;
		interval = 16'h0000;
		ignore = 4'h0;
		key_value = 32'h0000_0000;
		mode = lfwdt_pkg::LFWDT_ACTIVE;
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		check(bus.count_value_reg, 32'h0000_0000);
		check(bus.watchdog_reset_cause_bit, 32'h0000_0000);
		key_value = lfwdt_pkg::DISABLE_KEY;
		pulse(key_write);
		check(bus.reset_disabled, 32'h0000_0001);
		interval = 16'(1 + $urandom() % 3);
		ignore = 4'hE;
		m = bus.count_value_reg + interval;
		pulse(start);
		repeat (4) @(negedge clk);
		check(bus.match_value_reg, m);
		check(bus.ignore_bits, ignore);
		check(cpu_irq_enable_set, 32'h0000_0001);
		for (int k = 0; k < 4; k++)
			exp_q.push_back(m + 16'(k) * interval);
		wait_q(2);
		mode = lfwdt_pkg::LFWDT_SLEEP;
		wait_q(0);
		// re-arm the reset: the routine stops servicing, third unserviced match resets
		key_value = $urandom() & 32'h7FFF_FFFF;
		pulse(key_write);
		check(bus.reset_disabled, 32'h0000_0000);
		n = 0;
		while (!device_reset && n < 40000) begin
			@(negedge clk);
			n++;
		end
		check(device_reset, 32'h0000_0001);
		check(bus.watchdog_reset_cause_bit, 32'h0000_0001);
		@(negedge clk);
		check(device_reset, 32'h0000_0000);
		check(reset_cause_seen, 32'h0000_0001);
		check(bus.match_flag, 32'h0000_0001);
		pulse(service);
		check(bus.match_flag, 32'h0000_0000);
		pulse(cause_clear);
		check(reset_cause_seen, 32'h0000_0000);
		check(device_reset, 32'h0000_0000);
		stop_test();
	end
endmodule // lfwdt_tb
